// ===== inc/pcrp_cfg.svh
`ifndef PCRP_CFG_SVH
`define PCRP_CFG_SVH

// Byte offsets in the function's configuration space
`define PCRP_CAPL_OFS 8'h6C
`define PCRP_CAP_OFS 8'h6E
`define PCRP_DEVCAP_OFS 8'h70

// Field positions within the 32-bit configuration dword
`define PCRP_STRUCT_ID_LSB 0
`define PCRP_NEXT_PTR_LSB 8
`define PCRP_VERSION_LSB 16
`define PCRP_PORT_TYPE_LSB 20
`define PCRP_SLOT_BIT 24
`define PCRP_IMO_LSB 25
`define PCRP_DEVCAP_LOW_LSB 0
`define PCRP_L0S_LAT_LSB 6
`define PCRP_L1_LAT_LSB 9
`define PCRP_PLV_LSB 18
`define PCRP_PLS_LSB 26

// Byte lane that carries the slot-implemented bit
`define PCRP_SLOT_LANE 3

// Fixed and reset values
`define PCRP_STRUCT_ID 8'h10
`define PCRP_NEXT_PTR 8'h00
`define PCRP_IMO 5'h00
`define PCRP_PORT_TYPE 4'h4
`define PCRP_VERSION 4'h1
`define PCRP_SLOT_RST 1'h0
`define PCRP_PLS 2'h0
`define PCRP_PLV 8'h00
`define PCRP_L1_LAT 3'h7
`define PCRP_L0S_LAT 3'h7
`define PCRP_DEVCAP_LOW 6'h00

`endif

// ===== inc/pcrp_pkg.sv
`default_nettype none

package pcrp_pkg;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} pcrp_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
	} pcrp_rsp_t;

	typedef enum logic [1:0] {
		PCRP_SLOT_OPEN = 2'h1,
		PCRP_SLOT_LOCKED = 2'h2
	} pcrp_slot_state_t;

endpackage

`default_nettype wire

// ===== src/pcrp_cap_header.sv
// Operation
// - next pointer reads zero, read-only
// - low byte returns identifier 10h
// - message offset field reads zero, read-only
// - slot bit shows slot versus fixed device
// - slot bit takes only first slot-lane write
// - port type reads root port 0100b
// - structure version reads 0001b
// - power limit scale hardwired zero
// - power limit value hardwired zero
`include "pcrp_cfg.svh"

`default_nettype none

module pcrp_cap_header
	import pcrp_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire pcrp_req_t cfg_req,
	output var pcrp_rsp_t cfg_rsp,
	output logic slot_implemented
);

	pcrp_slot_state_t slot_state_q;
	logic slot_q;
	pcrp_rsp_t rsp_q;
	logic [31:0] rd_word;
	logic [5:0] dw_idx;
	logic hit_capl;
	logic hit_devcap;
	logic slot_write;
	logic rd_capl;
	logic rd_devcap;
	logic rd_unmapped;
	logic wr_any;

	// Config space is dword addressed; low address bits only matter via byte enables
	assign dw_idx = cfg_req.addr[7:2];
	assign hit_capl = (dw_idx == 6'(`PCRP_CAPL_OFS >> 2));
	assign hit_devcap = (dw_idx == 6'(`PCRP_DEVCAP_OFS >> 2));
	assign slot_write = cfg_req.valid && cfg_req.write && hit_capl && cfg_req.be[`PCRP_SLOT_LANE];

	// Write-once lock: firmware sets the slot topology a single time per reset
	always_ff @(posedge clk) begin
		if (reset) begin
			slot_state_q <= PCRP_SLOT_OPEN;
		end else begin
			case (slot_state_q)
				PCRP_SLOT_OPEN: begin
					if (slot_write) begin
						slot_state_q <= PCRP_SLOT_LOCKED;
					end
				end
				PCRP_SLOT_LOCKED: begin
					slot_state_q <= PCRP_SLOT_LOCKED;
				end
				default: begin
					slot_state_q <= PCRP_SLOT_LOCKED;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			slot_q <= `PCRP_SLOT_RST;
		end else if (slot_write && slot_state_q == PCRP_SLOT_OPEN) begin
			slot_q <= cfg_req.wdata[`PCRP_SLOT_BIT];
		end
	end

	// Read data assembly; everything not placed stays zero
	always_comb begin
		rd_word = 32'h0000_0000;
		if (hit_capl) begin
			rd_word[`PCRP_STRUCT_ID_LSB +: 8] = `PCRP_STRUCT_ID;
			rd_word[`PCRP_NEXT_PTR_LSB +: 8] = `PCRP_NEXT_PTR;
			rd_word[`PCRP_VERSION_LSB +: 4] = `PCRP_VERSION;
			rd_word[`PCRP_PORT_TYPE_LSB +: 4] = `PCRP_PORT_TYPE;
			rd_word[`PCRP_SLOT_BIT] = slot_q;
			rd_word[`PCRP_IMO_LSB +: 5] = `PCRP_IMO;
		end else if (hit_devcap) begin
			rd_word[`PCRP_DEVCAP_LOW_LSB +: 6] = `PCRP_DEVCAP_LOW;
			rd_word[`PCRP_L0S_LAT_LSB +: 3] = `PCRP_L0S_LAT;
			rd_word[`PCRP_L1_LAT_LSB +: 3] = `PCRP_L1_LAT;
			rd_word[`PCRP_PLV_LSB +: 8] = `PCRP_PLV;
			rd_word[`PCRP_PLS_LSB +: 2] = `PCRP_PLS;
		end
	end

	// Every access completes in one cycle; unmapped dwords read zero and drop writes
	always_ff @(posedge clk) begin
		if (reset) begin
			rsp_q <= '0;
		end else begin
			rsp_q.ack <= cfg_req.valid;
			if (cfg_req.valid && !cfg_req.write) begin
				rsp_q.rdata <= rd_word;
			end else begin
				rsp_q.rdata <= 32'h0000_0000;
			end
		end
	end

	assign cfg_rsp = rsp_q;
	assign slot_implemented = slot_q;

	default clocking dflt_cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// Read strobes per decoded dword, shared by the checks below
	assign rd_capl = cfg_req.valid && !cfg_req.write && hit_capl;
	assign rd_devcap = cfg_req.valid && !cfg_req.write && hit_devcap;
	assign rd_unmapped = cfg_req.valid && !cfg_req.write && !hit_capl && !hit_devcap;
	assign wr_any = cfg_req.valid && cfg_req.write;

	next_ptr_zero_a: assert property (rd_capl |=> cfg_rsp.ack && cfg_rsp.rdata[15:8] == 8'h00)
		else $error("next pointer not zero");

	struct_id_a: assert property (rd_capl |=> cfg_rsp.rdata[7:0] == 8'h10)
		else $error("structure identifier wrong");

	msg_offset_a: assert property (rd_capl |=> cfg_rsp.rdata[29:25] == 5'h00)
		else $error("message offset not zero");

	slot_read_a: assert property (rd_capl |=> cfg_rsp.rdata[24] == $past(slot_implemented))
		else $error("slot bit readback mismatch");

	slot_first_write_a: assert property (
		slot_write && slot_state_q == PCRP_SLOT_OPEN
		|=> slot_implemented == $past(cfg_req.wdata[24]) && slot_state_q == PCRP_SLOT_LOCKED)
		else $error("first slot write not taken");

	slot_locked_a: assert property (slot_state_q == PCRP_SLOT_LOCKED |=> $stable(slot_implemented)[*3])
		else $error("slot bit changed after lock");

	port_type_a: assert property (rd_capl |=> cfg_rsp.rdata[23:20] == 4'h4)
		else $error("port type not root port");

	version_a: assert property (rd_capl |=> cfg_rsp.rdata[19:16] == 4'h1)
		else $error("structure version wrong");

	limit_scale_a: assert property (rd_devcap |=> cfg_rsp.ack && cfg_rsp.rdata[27:26] == 2'h0)
		else $error("power limit scale not zero");

	limit_value_a: assert property (rd_devcap |=> cfg_rsp.rdata[25:18] == 8'h00)
		else $error("power limit value not zero");

	reserved_zero_a: assert property (
		rd_devcap |=> cfg_rsp.rdata[31:28] == 4'h0 && cfg_rsp.rdata[17:15] == 3'h0)
		else $error("reserved device bits nonzero");

	reserved_hdr_a: assert property (rd_capl |=> cfg_rsp.rdata[31:30] == 2'h0)
		else $error("reserved header bits nonzero");

	unmapped_zero_a: assert property (rd_unmapped |=> cfg_rsp.rdata == 32'h0000_0000)
		else $error("unmapped read nonzero");

	ack_timing_a: assert property (!cfg_req.valid |=> !cfg_rsp.ack)
		else $error("spurious acknowledge");

	// Whole-word views catch a field that lands in the wrong lane
	hdr_word_a: assert property (
		rd_capl
		|=> cfg_rsp.rdata == {2'h0, 5'h00, $past(slot_implemented), 4'h4, 4'h1, 8'h00, 8'h10})
		else $error("header word mismatch");

	devcap_word_a: assert property (
		rd_devcap
		|=> cfg_rsp.rdata == 32'h0000_0FC0)
		else $error("device word mismatch");

	devcap_latency_a: assert property (
		rd_devcap
		|=> cfg_rsp.rdata[11:6] == 6'h3F && cfg_rsp.rdata[5:0] == 6'h00)
		else $error("latency fields wrong");

	devcap_flags_a: assert property (rd_devcap |=> cfg_rsp.rdata[14:12] == 3'h0)
		else $error("indicator flags not zero");

	// Handshake: one answer per request, nothing left over between them
	ack_follow_a: assert property (cfg_req.valid |=> cfg_rsp.ack)
		else $error("request not acknowledged");

	write_quiet_a: assert property (
		wr_any
		|=> cfg_rsp.ack && cfg_rsp.rdata == 32'h0000_0000)
		else $error("write returned data");

	idle_quiet_a: assert property (
		!cfg_req.valid
		|=> cfg_rsp.rdata == 32'h0000_0000)
		else $error("idle data not zero");

	// Write-once lock: reopened only by reset, closed by the first slot-lane write
	slot_reset_a: assert property (
		$fell(reset)
		|-> !slot_implemented && !cfg_rsp.ack && slot_state_q == PCRP_SLOT_OPEN)
		else $error("lock not reopened by reset");

	lock_kept_a: assert property (
		slot_state_q == PCRP_SLOT_LOCKED
		|=> slot_state_q == PCRP_SLOT_LOCKED)
		else $error("lock released without reset");

	open_kept_a: assert property (
		slot_state_q == PCRP_SLOT_OPEN && !slot_write
		|=> slot_state_q == PCRP_SLOT_OPEN && $stable(slot_implemented))
		else $error("slot changed without a slot write");

	lane_ignore_a: assert property (
		wr_any && hit_capl && !cfg_req.be[3]
		|=> $stable(slot_implemented) && $stable(slot_state_q))
		else $error("lower lane write touched slot");

	unmapped_write_a: assert property (
		wr_any && !hit_capl
		|=> $stable(slot_implemented) && $stable(slot_state_q))
		else $error("foreign write touched slot");

	// A corrupted lock code falls to the default branch, which locks the slot bit
	state_onehot_a: assert property ($onehot(slot_state_q))
		else $error("lock state not one-hot");

endmodule

`default_nettype wire

// ===== test/tb_top.sv
`include "pcrp_cfg.svh"

`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pcrp_pkg::*;

	localparam logic [31:0] HDR = 32'h00410010;
	localparam logic [31:0] DEVCAP = 32'h00000FC0;
	localparam logic [31:0] SLOT1 = 32'h01000000;

	logic clk = 1'b0;
	logic reset = 1'b1;
	pcrp_req_t req = '0;
	pcrp_rsp_t rsp;
	logic slot;
	logic [31:0] r;
	int err_count = 0;
	int cmp_count = 0;
	int cyc = 0;

	pcrp_cap_header i_dut (.clk(clk), .reset(reset), .cfg_req(req), .cfg_rsp(rsp), .slot_implemented(slot));

	initial forever #4 clk = ~clk;

	task automatic end_sim;
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Whole run is well under 200 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_count++;
			end_sim();
		end
	end

	task automatic cmp32(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic cmp1(input string n, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %b got %b", n, e, g);
		end
	endtask

	// Answer is registered on the taking edge, so look at the next falling edge
	task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		@(negedge clk);
		req = '{1'b1, w, a, b, d};
		@(negedge clk);
		req.valid = 1'b0;
		cmp1("ack", 1'b1, rsp.ack);
		r = rsp.rdata;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		acc(1'b0, a, 4'hF, 32'hFFFFFFFF);
		cmp32("rdata", e, r);
	endtask

	task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		acc(1'b1, a, b, d);
		cmp32("write rdata", 32'h00000000, r);
	endtask

	task automatic do_reset;
		reset = 1'b1;
		repeat (8) @(negedge clk);
		reset = 1'b0;
	endtask

	initial begin
		do_reset();
		cmp1("slot", 1'b0, slot);
		rd(`PCRP_CAPL_OFS, HDR);
		rd(`PCRP_DEVCAP_OFS, DEVCAP);
		wr(`PCRP_DEVCAP_OFS, 4'hF, 32'hFFFFFFFF);
		rd(`PCRP_DEVCAP_OFS, DEVCAP);
		// Lower lanes must neither set nor lock the slot bit
		wr(`PCRP_CAPL_OFS, 4'h7, 32'hFFFFFFFF);
		rd(`PCRP_CAPL_OFS, HDR);
		wr(`PCRP_CAP_OFS, 4'h8, 32'hFFFFFFFF);
		cmp1("slot", 1'b1, slot);
		rd(`PCRP_CAPL_OFS, HDR | SLOT1);
		wr(`PCRP_CAPL_OFS, 4'h8, 32'h00000000);
		cmp1("slot", 1'b1, slot);
		rd(8'h74, 32'h00000000);
		do_reset();
		cmp1("slot", 1'b0, slot);
		wr(`PCRP_CAPL_OFS, 4'h8, 32'h00000000);
		wr(`PCRP_CAPL_OFS, 4'h8, 32'hFFFFFFFF);
		cmp1("slot", 1'b0, slot);
		rd(`PCRP_CAPL_OFS, HDR);
		end_sim();
	end
endmodule

`default_nettype wire
